// >>> rtl/sweep_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SWEEP_MAP_SVH
`define SWEEP_MAP_SVH
`define A_CTRL    6'h00
`define A_START   6'h04
`define A_STOP    6'h08
`define A_STEPS   6'h0C
`define A_DWELL   6'h10
`define A_CMD     6'h14
`define A_STAT    6'h18
`define A_VALUE   6'h1C
`define A_SET     6'h20
`define A_MK0     6'h28
`define A_MK4     6'h38
`define F_TYPE    0
`define F_MODE    3
`define F_FM      5
`define F_MKEN    6
`define F_OUTEN   7
`define F_TRIG    8
`define CTRL_MASK 32'h0000_07FF
`define CTRL_RST  32'h0000_0081
`define C_START   0
`define C_STOP    1
`define C_CONT    2
`define C_RESET   3
`define C_ABORT   4
`define C_INC     5
`define C_DEC     6
`define C_XFER    7
`define F_CALC    2
`define F_AVAIL   3
`define F_PROG    16
`define F_MKON    16
`define START_RST 16'h0000
`define STOP_RST  16'hFFFF
`define STEPS_RST 14'h03E8
`define DWELL_RST 16'h0032
`define LIM_FM    14'h00FA
`define LIM_CW    14'h03E8
`define LIM_GEN   14'h2710
`define CLK_HZ    20000000
`define TICK_US   1000
`define TICK_CYC  (`CLK_HZ / 1000000 * `TICK_US)
`endif

// >>> rtl/sweep_pkg.sv
// Types shared by the sweep sequencer.
package sweep_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CALC  = 2'b01,
        ST_SWEEP = 2'b10,
        ST_PAUSE = 2'b11
    } state_t;
    typedef enum logic [2:0] {
        TY_CARRIER = 3'b000,
        TY_LEVEL   = 3'b001,
        TY_MODRATE = 3'b010,
        TY_LFFREQ  = 3'b011,
        TY_LFLEVEL = 3'b100
    } stype_t;
    typedef enum logic [1:0] {
        MD_SINGLE = 2'b00,
        MD_CONT   = 2'b01,
        MD_EXT    = 2'b10
    } smode_t;
    typedef enum logic [2:0] {
        TF_NONE  = 3'b000,
        TF_START = 3'b001,
        TF_STEP  = 3'b010,
        TF_TONES = 3'b011,
        TF_RUP   = 3'b100,
        TF_RDN   = 3'b101
    } tfunc_t;
endpackage

// >>> rtl/sweep_sequencer.sv
// Stepped sweep sequencer with Avalon-MM register access.
`timescale 1ns/1ns
`include "sweep_map.svh"

module sweep_sequencer
    import sweep_pkg::*;
#(
    parameter int VW       = 16,
    parameter int SW       = 14,
    parameter int TICK_CYC = `TICK_CYC
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [5:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic      [31:0]   avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic          ext_trig_n,
    output logic               marker,
    output logic      [VW-1:0] sweep_value,
    output logic               rf_enable,
    output logic      [VW-1:0] setting_value,
    output logic               setting_load,
    output logic               tones_send,
    output logic               recall_up,
    output logic               recall_down
);
    localparam int BW = $clog2(VW + 1);
    localparam int TW = $clog2(TICK_CYC);

    if (VW < 2 || VW > 16 || SW < 14 || SW > 16 || TICK_CYC < 2)
    begin : g_chk
        $error("sweep_sequencer: unsupported parameter values");
    end

    logic [31:0]   ctrl_r;
    logic [VW-1:0] start_r;
    logic [VW-1:0] stop_r;
    logic [SW-1:0] steps_r;
    logic [15:0]   dwell_r;
    logic [VW-1:0] mk_val_r [5];
    logic [4:0]    mk_on_r;
    state_t        state_r;
    state_t        st_nxt;
    logic [SW-1:0] idx_r;
    logic [SW-1:0] idx_nxt;
    logic [VW-1:0] val_r;
    logic [VW-1:0] inc_r;
    logic [VW-1:0] dvd_r;
    logic [SW:0]   rem_r;
    logic [BW-1:0] bit_r;
    logic          calc_req_r;
    logic          avail_r;
    logic          ack_r;
    logic          trig_q_r;
    logic [TW-1:0] tick_r;
    logic [15:0]   dw_r;
    logic          marker_r;
    logic [VW-1:0] setting_r;
    logic          load_r;
    logic          tones_r;
    logic          rup_r;
    logic          rdn_r;
    logic          go;
    logic [31:0]   rd_mux;

    // Bus slave: one wait state, write lands when waitrequest is low.
    wire req  = avs_read | avs_write;
    wire wr   = avs_write & ack_r;
    wire rd   = avs_read & ~ack_r;
    wire [5:0] a = avs_address;
    wire [31:0] wd = avs_writedata;
    assign avs_waitrequest = req & ~ack_r;

    wire wr_ctrl  = wr && a == `A_CTRL;
    wire wr_start = wr && a == `A_START;
    wire wr_stop  = wr && a == `A_STOP;
    wire wr_steps = wr && a == `A_STEPS;
    wire wr_dwell = wr && a == `A_DWELL;
    wire wr_cmd   = wr && a == `A_CMD;
    wire mk_hit   = a >= `A_MK0 && a <= `A_MK4 && a[1:0] == 2'b00;
    wire [2:0] mk_sel = 3'(a[5:2] - `A_MK0 / 4);

    wire [7:0] cmd = wr_cmd ? wd[7:0] : 8'h00;
    wire c_start = cmd[`C_START];
    wire c_stop  = cmd[`C_STOP];
    wire c_cont  = cmd[`C_CONT];
    wire c_reset = cmd[`C_RESET];
    wire c_abort = cmd[`C_ABORT];
    wire c_inc   = cmd[`C_INC];
    wire c_dec   = cmd[`C_DEC];
    wire c_xfer  = cmd[`C_XFER];

    stype_t ctype;
    smode_t cmode;
    tfunc_t tfunc;
    assign ctype = stype_t'(ctrl_r[`F_TYPE +: 3]);
    assign cmode = smode_t'(ctrl_r[`F_MODE +: 2]);
    assign tfunc = tfunc_t'(ctrl_r[`F_TRIG +: 3]);
    wire fm_on = ctrl_r[`F_FM];
    wire mk_en = ctrl_r[`F_MKEN];
    wire rf_on = ctrl_r[`F_OUTEN];

    // The limit depends on sweep type and modulation.
    wire carrier = ctype == TY_CARRIER;
    wire [SW-1:0] lim = carrier ? (fm_on ? SW'(`LIM_FM) : SW'(`LIM_CW))
                                : SW'(`LIM_GEN);
    // Out of range counts are clamped rather than refused.
    wire [SW-1:0] steps_eff = (steps_r == '0) ? SW'(1)
                            : (steps_r > lim) ? lim : steps_r;

    wire dir_dn = stop_r < start_r;
    wire [VW-1:0] span = dir_dn ? start_r - stop_r : stop_r - start_r;

    // Restoring division of the span by the step count.
    wire [SW:0] trial = {rem_r[SW-1:0], dvd_r[VW-1]};
    wire ge = trial >= {1'b0, steps_eff};
    wire [SW:0] rem_nxt = ge ? trial - {1'b0, steps_eff} : trial;
    wire calc_go = state_r == ST_IDLE && calc_req_r;
    wire calc_end = state_r == ST_CALC && bit_r == BW'(VW - 1);
    wire busy = calc_req_r || state_r == ST_CALC;

    // The last point is forced to the stop value so rounding never shows.
    function automatic logic [VW-1:0] vfun(input logic [SW-1:0] k);
        logic [VW+SW-1:0] p;
        p = k * inc_r;
        if (k >= steps_eff)
            return stop_r;
        return dir_dn ? start_r - p[VW-1:0] : start_r + p[VW-1:0];
    endfunction
    wire [VW-1:0] vn = vfun(idx_nxt);

    // The trigger arrives already synchronised and debounced.
    wire trig_fall = trig_q_r & ~ext_trig_n;
    wire ext_mode = cmode == MD_EXT;
    wire ext_step = ext_mode && tfunc == TF_STEP;
    wire ext_start = trig_fall && ext_mode && tfunc == TF_START;

    // Millisecond enable for the dwell timer.
    wire tick = tick_r == TW'(TICK_CYC - 1);
    wire dwell_done = tick && dw_r + 16'h0001 >= dwell_r;
    // External step mode replaces the dwell timer by triggers.
    wire step_ev = ext_step ? trig_fall : dwell_done;
    wire last = idx_r >= steps_eff;

    always_comb begin
        st_nxt  = state_r;
        idx_nxt = idx_r;
        go      = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (calc_req_r) begin
                    st_nxt = ST_CALC;
                end else if (c_start || ext_start) begin
                    st_nxt  = ST_SWEEP;
                    idx_nxt = '0;
                    go      = 1'b1;
                end
            end
            ST_CALC: begin
                if (calc_end)
                    st_nxt = ST_IDLE;
            end
            ST_SWEEP: begin // Other commands are not decoded here.
                if (c_abort && avail_r) begin
                    st_nxt = ST_IDLE;
                end else if (c_stop) begin
                    st_nxt = ST_PAUSE;
                end else if (step_ev) begin
                    if (!last) begin
                        idx_nxt = idx_r + 1'b1;
                        go      = 1'b1;
                    end else if (cmode == MD_CONT) begin
                        idx_nxt = '0;
                        go      = 1'b1;
                    end else begin
                        st_nxt = ST_IDLE;
                    end
                end
            end
            ST_PAUSE: begin
                if (c_reset) begin
                    st_nxt = ST_IDLE;
                end else if (c_cont) begin
                    st_nxt = ST_SWEEP;
                end else if (c_inc && !last) begin
                    idx_nxt = idx_r + 1'b1;
                end else if (c_dec && idx_r != '0) begin
                    idx_nxt = idx_r - 1'b1;
                end
            end
        endcase
    end

    // A marker is hit when it lies on the stretch just swept.
    logic [4:0] hit;
    for (genvar k = 0; k < 5; k++) begin : g_mk
        wire [VW-1:0] m = mk_val_r[k];
        wire first = idx_nxt == '0;
        wire pass = dir_dn ? (m < val_r && m >= vn)
                           : (m > val_r && m <= vn);
        assign hit[k] = mk_on_r[k] && (first ? m == vn : pass);
    end

    wire [31:0] stat = {{(16 - SW){1'b0}}, idx_r, 12'h000,
                        avail_r, busy, state_r};
    assign rd_mux =
        (a == `A_CTRL)  ? ctrl_r :
        (a == `A_START) ? 32'(start_r) :
        (a == `A_STOP)  ? 32'(stop_r) :
        (a == `A_STEPS) ? 32'(steps_eff) :
        (a == `A_DWELL) ? 32'(dwell_r) :
        (a == `A_STAT)  ? stat :
        (a == `A_VALUE) ? 32'(val_r) :
        (a == `A_SET)   ? 32'(setting_r) :
        mk_hit ? (32'(mk_val_r[mk_sel]) |
                 (32'(mk_on_r[mk_sel]) << `F_MKON)) : 32'h0000_0000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_r <= req & ~ack_r;
            if (rd)
                avs_readdata <= rd_mux;
        end
    end

    // Abort clears the output enable even against a same-cycle write.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r  <= `CTRL_RST;
            start_r <= VW'(`START_RST);
            stop_r  <= VW'(`STOP_RST);
            steps_r <= SW'(`STEPS_RST);
            dwell_r <= `DWELL_RST;
        end else begin
            if (wr_ctrl)
                ctrl_r <= wd & `CTRL_MASK;
            if (state_r == ST_SWEEP && c_abort && avail_r)
                ctrl_r[`F_OUTEN] <= 1'b0;
            if (wr_start)
                start_r <= wd[VW-1:0];
            if (wr_stop)
                stop_r <= wd[VW-1:0];
            if (wr_steps)
                steps_r <= wd[SW-1:0];
            if (wr_dwell)
                dwell_r <= wd[15:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mk_on_r <= 5'h00;
            for (int i = 0; i < 5; i++)
                mk_val_r[i] <= '0;
        end else if (wr && mk_hit) begin
            mk_val_r[mk_sel] <= wd[VW-1:0];
            mk_on_r[mk_sel]  <= wd[`F_MKON];
        end
    end

    // A write during a calculation queues a fresh one; set beats clear.
    wire wr_param = wr_ctrl | wr_start | wr_stop | wr_steps;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            calc_req_r <= 1'b1;
            dvd_r      <= '0;
            rem_r      <= '0;
            bit_r      <= '0;
            inc_r      <= '0;
        end else begin
            calc_req_r <= wr_param | (calc_req_r & ~calc_go);
            if (calc_go) begin
                dvd_r <= span;
                rem_r <= '0;
                bit_r <= '0;
            end else if (state_r == ST_CALC) begin
                dvd_r <= {dvd_r[VW-2:0], ge};
                rem_r <= rem_nxt;
                bit_r <= bit_r + 1'b1;
                if (calc_end)
                    inc_r <= {dvd_r[VW-2:0], ge};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            idx_r   <= '0;
            val_r   <= '0;
            avail_r <= 1'b0;
        end else begin
            state_r <= st_nxt;
            idx_r   <= idx_nxt;
            val_r   <= vn;
            if (state_r == ST_IDLE && st_nxt == ST_SWEEP)
                avail_r <= rf_on;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_r <= '0;
            dw_r   <= 16'h0000;
        end else begin
            tick_r <= tick ? '0 : tick_r + 1'b1;
            if (state_r != ST_SWEEP || go || dwell_done)
                dw_r <= 16'h0000;
            else if (tick)
                dw_r <= dw_r + 16'h0001;
        end
    end

    // The pulse spans from one step advance to the next.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            marker_r <= 1'b0;
        end else if (!mk_en || st_nxt != ST_SWEEP) begin
            marker_r <= 1'b0;
        end else if (go) begin
            marker_r <= |hit;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_q_r  <= 1'b1;
            tones_r   <= 1'b0;
            rup_r     <= 1'b0;
            rdn_r     <= 1'b0;
            setting_r <= '0;
            load_r    <= 1'b0;
        end else begin
            trig_q_r <= ext_trig_n;
            tones_r  <= trig_fall && tfunc == TF_TONES;
            rup_r    <= trig_fall && tfunc == TF_RUP;
            rdn_r    <= trig_fall && tfunc == TF_RDN;
            load_r   <= 1'b0;
            if (state_r == ST_PAUSE && c_xfer && !c_reset && !c_cont) begin
                setting_r <= val_r;
                load_r    <= 1'b1;
            end
        end
    end

    assign marker        = marker_r;
    assign sweep_value   = val_r;
    assign rf_enable     = rf_on;
    assign setting_value = setting_r;
    assign setting_load  = load_r;
    assign tones_send    = tones_r;
    assign recall_up     = rup_r;
    assign recall_down   = rdn_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire in_sw = state_r == ST_SWEEP;
    sequence s_calc_go;
        state_r == ST_IDLE && calc_req_r;
    endsequence
    sequence s_abort;
        in_sw && c_abort && avail_r;
    endsequence

    property p_clamp;
        steps_eff != '0 && steps_eff <= lim;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("step count not clamped");
    property p_fm;
        carrier && fm_on |-> steps_eff <= SW'(`LIM_FM);
    endproperty
    a_fm: assert property (p_fm)
        else $error("modulated carrier steps above limit");
    property p_cw;
        carrier && !fm_on |-> steps_eff <= SW'(`LIM_CW);
    endproperty
    a_cw: assert property (p_cw)
        else $error("carrier steps above limit");
    property p_gen;
        !carrier && steps_r <= SW'(`LIM_GEN) && steps_r != '0
            |-> steps_eff == steps_r;
    endproperty
    a_gen: assert property (p_gen)
        else $error("valid step count altered");
    property p_calc;
        s_calc_go |=> busy [*8] ##[1:20] state_r == ST_IDLE;
    endproperty
    a_calc: assert property (p_calc)
        else $error("calculating status wrong");
    property p_start;
        state_r == ST_IDLE && !calc_req_r && c_start
            |=> in_sw && idx_r == '0;
    endproperty
    a_start: assert property (p_start)
        else $error("start did not begin sweep");
    property p_ign;
        in_sw && c_xfer |=> $stable(setting_r) && !setting_load;
    endproperty
    a_ign: assert property (p_ign)
        else $error("command obeyed while sweeping");
    property p_stop;
        in_sw && c_stop && !(c_abort && avail_r)
            |=> state_r == ST_PAUSE && $stable(idx_r);
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not pause");
    property p_inc;
        state_r == ST_PAUSE && c_inc && !last
            |=> idx_r == $past(idx_r) + 1'b1;
    endproperty
    a_inc: assert property (p_inc)
        else $error("increment while paused failed");
    property p_xfer;
        state_r == ST_PAUSE && c_xfer && !c_reset && !c_cont
            |=> setting_load && setting_value == $past(val_r);
    endproperty
    a_xfer: assert property (p_xfer)
        else $error("transfer failed");
    property p_abort;
        s_abort |=> state_r == ST_IDLE && !rf_enable;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort failed");
    property p_mk;
        !mk_en |=> !marker;
    endproperty
    a_mk: assert property (p_mk)
        else $error("marker not gated");
    property p_mkhold;
        marker && in_sw && !go && !c_stop && !c_abort && mk_en
            && !(step_ev && last) |=> marker;
    endproperty
    a_mkhold: assert property (p_mkhold)
        else $error("marker dropped inside a step");
    property p_xstep;
        in_sw && ext_step && !trig_fall |=> $stable(idx_r);
    endproperty
    a_xstep: assert property (p_xstep)
        else $error("external step moved without trigger");
    property p_trig;
        trig_fall |=> !trig_fall;
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger acted twice");
    property p_single;
        in_sw && step_ev && last && cmode == MD_SINGLE && !c_stop
            && !c_abort |=> state_r == ST_IDLE;
    endproperty
    a_single: assert property (p_single)
        else $error("single sweep did not finish");
endmodule // sweep_sequencer

// >>> tb/trig_source.sv
// External trigger source model driving the rear trigger input.
`timescale 1ns/1ns
module trig_source #(
    parameter int LOW_CYC = 3
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic fire,
    output logic      ext_trig_n
);
    int cnt;
    // A clean, clock-aligned low pulse; the line returns to the pull-up
    // level, so each request gives exactly one falling edge.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            ext_trig_n <= 1'b1;
        end else if (fire && cnt == 0) begin
            cnt <= LOW_CYC;
            ext_trig_n <= 1'b0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            ext_trig_n <= (cnt == 1);
        end
    end
endmodule // trig_source

// >>> tb/sweep_sequencer_bench.sv
// Self-checking bench for the sweep sequencer.
`timescale 1ns/1ns
`include "sweep_map.svh"
module sweep_sequencer_bench;
    localparam int TK = 8;
    logic        clk = 0;
    logic        rst_n = 0;
    logic [5:0]  avs_address = 0;
    logic        avs_read = 0;
    logic        avs_write = 0;
    logic [31:0] avs_writedata = 0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ext_trig_n;
    logic        fire = 0;
    logic        marker;
    logic        rf_enable;
    logic        setting_load;
    logic        tones_send;
    logic        recall_up;
    logic        recall_down;
    logic [15:0] sweep_value;
    logic [15:0] setting_value;
    logic [15:0] prev_v = 0;
    logic [31:0] q;
    logic [31:0] v;
    logic [23:0] pcnt = 0;
    logic [23:0] e = 0;
    int          bad_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          mk = 0;
    int          ld = 0;
    int          hit = 0;
    int          wrap = 0;
    int          m0;
    int          h0;

    always #25 clk = ~clk;

    sweep_sequencer #(.TICK_CYC(TK)) dut (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_trig_n(ext_trig_n),
        .marker(marker), .sweep_value(sweep_value), .rf_enable(rf_enable),
        .setting_value(setting_value), .setting_load(setting_load),
        .tones_send(tones_send), .recall_up(recall_up),
        .recall_down(recall_down)
    );

    trig_source src (.clk(clk), .rst_n(rst_n), .fire(fire),
                     .ext_trig_n(ext_trig_n));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        mk <= mk + marker;
        ld <= ld + setting_load;
        hit <= hit + (sweep_value == 16'h0028 && prev_v != 16'h0028);
        wrap <= wrap + (prev_v == 16'h0028 && sweep_value == 16'h0000);
        prev_v <= sweep_value;
        pcnt <= pcnt + {7'h0, tones_send, 7'h0, recall_up, 7'h0, recall_down};
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
        end
    endtask

    // Holds the request until the rising edge at which waitrequest is low;
    // read data is taken at that same edge and only then is it released.
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        chk({31'h0, avs_waitrequest}, 32'h0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask

    task poll(input logic [31:0] m, input logic [31:0] x);
        int n;
        n = 0;
        do begin
            bus(1'b0, `A_STAT, 32'h0);
            n++;
        end while ((q & m) !== x && n < 200);
        chk(q & m, x);
    endtask

    task trig;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task end_sim;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`A_CTRL, 32'hFFFFFFFF, `CTRL_RST);
        rdc(`A_STEPS, 32'h3FFF, 32'h03E8);
        rdc(6'h3C, 32'hFFFFFFFF, 32'h0);
        wr(`A_CTRL, 32'h020);
        wr(`A_STEPS, 32'd5000);
        rdc(`A_STEPS, 32'h3FFF, 32'd250);
        wr(`A_CTRL, 32'h001);
        wr(`A_STEPS, 32'd12000);
        rdc(`A_STEPS, 32'h3FFF, 32'd10000);
        wr(`A_STEPS, 32'h0);
        rdc(`A_STEPS, 32'h3FFF, 32'h1);
        rdc(`A_STAT, 32'h4, 32'h4);
        wr(`A_CTRL, 32'h0C1);
        wr(`A_START, 32'h0);
        wr(`A_STOP, 32'h28);
        wr(`A_STEPS, 32'h4);
        wr(`A_DWELL, 32'h1);
        wr(`A_MK0, 32'h0001_0014);
        poll(32'h4, 32'h0);
        m0 = mk;
        h0 = hit;
        wr(`A_CMD, 32'h01);
        rdc(`A_STAT, 32'h3, 32'h2);
        wr(`A_CMD, 32'h08);
        rdc(`A_STAT, 32'h3, 32'h2);
        poll(32'h3, 32'h0);
        chk(hit - h0, 1);
        chk(mk - m0, TK);
        // Continuous mode must wrap from the stop value back to start.
        wr(`A_CTRL, 32'h0C9);
        poll(32'h4, 32'h0);
        h0 = wrap;
        wr(`A_CMD, 32'h01);
        repeat (100) @(posedge clk);
        chk({31'h0, wrap > h0}, 32'h1);
        wr(`A_CMD, 32'h10);
        rdc(`A_STAT, 32'h3, 32'h0);
        chk({31'h0, rf_enable}, 32'h0);
        wr(`A_CTRL, 32'h049);
        poll(32'h4, 32'h0);
        wr(`A_CMD, 32'h01);
        rdc(`A_STAT, 32'h8, 32'h0);
        wr(`A_CMD, 32'h10);
        rdc(`A_STAT, 32'h3, 32'h2);
        wr(`A_CMD, 32'h02);
        rdc(`A_STAT, 32'h3, 32'h3);
        bus(1'b0, `A_VALUE, 32'h0);
        v = q + 32'hA;
        wr(`A_CMD, 32'h20);
        rdc(`A_VALUE, 32'hFFFF, v);
        m0 = ld;
        wr(`A_CMD, 32'h80);
        repeat (3) @(negedge clk);
        chk({16'h0, setting_value}, v);
        chk(ld - m0, 1);
        wr(`A_CMD, 32'h04);
        rdc(`A_STAT, 32'h3, 32'h2);
        wr(`A_CMD, 32'h02);
        wr(`A_CMD, 32'h08);
        rdc(`A_STAT, 32'h3, 32'h0);
        wr(`A_CTRL, 32'h291);
        poll(32'h4, 32'h0);
        wr(`A_CMD, 32'h01);
        rdc(`A_VALUE, 32'hFFFF, 32'h0);
        trig();
        rdc(`A_VALUE, 32'hFFFF, 32'hA);
        repeat (4 * TK) @(posedge clk);
        rdc(`A_VALUE, 32'hFFFF, 32'hA);
        wr(`A_CMD, 32'h02);
        wr(`A_CMD, 32'h08);
        // Only the tones and recall functions give a pulse when idle.
        for (int f = 0; f < 6; f++) begin
            wr(`A_CTRL, {21'h0, f[2:0], 8'h91});
            trig();
            e = e + (f == 3 ? 24'h010000 : f == 4 ? 24'h000100 :
                     f == 5 ? 24'h000001 : 24'h0);
            chk({8'h0, pcnt}, {8'h0, e});
        end
        end_sim();
    end
endmodule // sweep_sequencer_bench
